// file: hw/lgpc_top.v
// Contract
// R01: Mode 00 routes pin to functional input; mode 10 holds pin high impedance.
// R02: Mode 01 makes pin software output; mode 11 makes it software input.
// R03: Output value bit drives pin only in software output mode.
// R04: Value 0 drives low, 1 drives high; value resets to 0.
// R05: Upper pin mode in bits 5:4, lower pin mode in bits 1:0.
// R06: Upper value in bit 7, lower in bit 3; pins 7/8 reset 0x00.
// R07: Reserved bits 6 and 2 read zero and ignore writes.
`include "lgpc_consts.vh"

module lgpc_top (
  input  wire        REF_CLK,
  input  wire        RST_N,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [31:0] WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  input  wire [3:0]  FUNC_OUT,
  output wire [3:0]  FUNC_IN,
  input  wire [3:0]  AUX_IO_PIN_I,
  output wire [3:0]  AUX_IO_PIN_O,
  output wire [3:0]  AUX_IO_PIN_OE_N
);
  reg  [7:0] aux_pins_5_6_config_reg;
  reg  [7:0] aux_pins_7_8_config_reg;
  reg  [7:0] cfg_next_56;
  reg  [7:0] cfg_next_78;
  reg  [31:0] rd_next;
  wire [3:0] sw_in;
  wire [1:0] mode   [0:3];
  wire [3:0] out_val;
  wire       req;
  wire       wr_ok;
  wire [7:0] idx;

  assign req   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wr_ok = req & WB_WE_I & WB_SEL_I[0];
  assign idx   = WB_ADR_I[`LGPC_ADR_W+1:2];

  // Masked write keeps reserved bits at zero
  function [7:0] wr_field;
    input [7:0] wdata;
    begin
      wr_field = wdata & `LGPC_WR_MASK; // R07
    end
  endfunction

  function hit;
    input [7:0] index;
    input [7:0] target;
    begin
      hit = (WB_ADR_I[31:`LGPC_ADR_W+2] == 0) &&
            (WB_ADR_I[1:0] == 2'b00) && (index == target);
    end
  endfunction

  always @* begin
    cfg_next_56 = aux_pins_5_6_config_reg;
    cfg_next_78 = aux_pins_7_8_config_reg;
    if (wr_ok && hit(idx, `LGPC_IDX_PINS_5_6))
      cfg_next_56 = wr_field(WB_DAT_I[7:0]); // R05 R06
    if (wr_ok && hit(idx, `LGPC_IDX_PINS_7_8))
      cfg_next_78 = wr_field(WB_DAT_I[7:0]); // R05 R06
  end

  always @* begin
    rd_next = 32'h0000_0000;
    if (hit(idx, `LGPC_IDX_PINS_5_6))
      rd_next = {24'h00_0000, aux_pins_5_6_config_reg}; // R07
    else if (hit(idx, `LGPC_IDX_PINS_7_8))
      rd_next = {24'h00_0000, aux_pins_7_8_config_reg}; // R07
    else if (hit(idx, `LGPC_IDX_PINS_IN))
      rd_next = {28'h000_0000, sw_in};
  end

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      aux_pins_5_6_config_reg <= `LGPC_RST_PINS_5_6; // R04
      aux_pins_7_8_config_reg <= `LGPC_RST_PINS_7_8; // R06
      WB_ACK_O                <= 1'b0;
      WB_DAT_O                <= 32'h0000_0000;
    end else begin
      aux_pins_5_6_config_reg <= cfg_next_56;
      aux_pins_7_8_config_reg <= cfg_next_78;
      WB_ACK_O                <= req;
      WB_DAT_O                <= req ? rd_next : 32'h0000_0000;
    end
  end

  // Pin order: 0=pin 5, 1=pin 6, 2=pin 7, 3=pin 8
  assign mode[0] =
    aux_pins_5_6_config_reg[`LGPC_LO_MODE_MSB:`LGPC_LO_MODE_LSB]; // R05
  assign mode[1] =
    aux_pins_5_6_config_reg[`LGPC_HI_MODE_MSB:`LGPC_HI_MODE_LSB]; // R05
  assign mode[2] =
    aux_pins_7_8_config_reg[`LGPC_LO_MODE_MSB:`LGPC_LO_MODE_LSB]; // R05
  assign mode[3] =
    aux_pins_7_8_config_reg[`LGPC_HI_MODE_MSB:`LGPC_HI_MODE_LSB]; // R05
  assign out_val = {aux_pins_7_8_config_reg[`LGPC_HI_VAL_BIT],
                    aux_pins_7_8_config_reg[`LGPC_LO_VAL_BIT],
                    aux_pins_5_6_config_reg[`LGPC_HI_VAL_BIT],
                    aux_pins_5_6_config_reg[`LGPC_LO_VAL_BIT]}; // R06

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : pin
      lgpc_pin_ctrl u_pin (
        .clk          (REF_CLK),
        .rst_n        (RST_N),
        .mode         (mode[g]),
        .out_val      (out_val[g]),
        .func_out     (FUNC_OUT[g]),
        .pin_in       (AUX_IO_PIN_I[g]),
        .pin_out_reg  (AUX_IO_PIN_O[g]),
        .pin_oe_n_reg (AUX_IO_PIN_OE_N[g]),
        .func_in_reg  (FUNC_IN[g]),
        .sw_in_reg    (sw_in[g])
      );
    end
  endgenerate
endmodule

// file: common/lgpc_consts.vh
`ifndef LGPC_CONSTS_VH
`define LGPC_CONSTS_VH

// Register indices, byte address is four times the index
`define LGPC_IDX_PINS_5_6   8'h10
`define LGPC_IDX_PINS_7_8   8'h11
`define LGPC_IDX_PINS_IN    8'h12
`define LGPC_ADR_W          8

`define LGPC_RST_PINS_5_6   8'h00
`define LGPC_RST_PINS_7_8   8'h00

// Field positions within a paired register
`define LGPC_HI_VAL_BIT     7
`define LGPC_HI_MODE_MSB    5
`define LGPC_HI_MODE_LSB    4
`define LGPC_LO_VAL_BIT     3
`define LGPC_LO_MODE_MSB    1
`define LGPC_LO_MODE_LSB    0
`define LGPC_WR_MASK        8'hBB

// Mode encodings
`define LGPC_MODE_FUNC      2'b00
`define LGPC_MODE_OUT       2'b01
`define LGPC_MODE_HIZ       2'b10
`define LGPC_MODE_IN        2'b11

`endif

// file: hw/lgpc_pin_ctrl.v
`include "lgpc_consts.vh"

// One pin: mode decode, drive and input capture
module lgpc_pin_ctrl (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [1:0] mode,
  input  wire       out_val,
  input  wire       func_out,
  input  wire       pin_in,
  output reg        pin_out_reg,
  output reg        pin_oe_n_reg,
  output reg        func_in_reg,
  output reg        sw_in_reg
);
  reg meta_reg;
  reg sync_reg;
  reg pin_out_next;
  reg oe_n_next;

  always @* begin
    pin_out_next = 1'b0;
    oe_n_next    = 1'b1;
    case (mode)
      `LGPC_MODE_FUNC: begin // R01
        pin_out_next = func_out;
        oe_n_next    = 1'b1;
      end
      `LGPC_MODE_OUT: begin // R02
        pin_out_next = out_val; // R03 R04
        oe_n_next    = 1'b0;
      end
      `LGPC_MODE_HIZ: begin // R01
        oe_n_next    = 1'b1;
      end
      `LGPC_MODE_IN: begin // R02
        oe_n_next    = 1'b1;
      end
      default: begin
        oe_n_next    = 1'b1;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg     <= 1'b0;
      sync_reg     <= 1'b0;
      pin_out_reg  <= 1'b0;
      pin_oe_n_reg <= 1'b1;
      func_in_reg  <= 1'b0;
      sw_in_reg    <= 1'b0;
    end else begin
      meta_reg     <= pin_in;
      sync_reg     <= meta_reg;
      pin_out_reg  <= pin_out_next;
      pin_oe_n_reg <= oe_n_next;
      // Functional input only sees the pin in functional mode
      func_in_reg  <= (mode == `LGPC_MODE_FUNC) ? sync_reg : 1'b0; // R01
      sw_in_reg    <= sync_reg;
    end
  end
endmodule

// file: tb/lgpc_chk_props.sv
module lgpc_chk (
  input logic        REF_CLK,
  input logic        RST_N,
  input logic        WB_CYC_I,
  input logic        WB_STB_I,
  input logic        WB_WE_I,
  input logic [31:0] WB_ADR_I,
  input logic [3:0]  WB_SEL_I,
  input logic [31:0] WB_DAT_I,
  input logic [31:0] WB_DAT_O,
  input logic        WB_ACK_O,
  input logic [3:0]  FUNC_IN,
  input logic [3:0]  AUX_IO_PIN_O,
  input logic [3:0]  AUX_IO_PIN_OE_N
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cfg_reg;
  wire         req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire         sel = WB_ADR_I[31:3] == 29'h8;
  wire [7:0]   wd = WB_DAT_I[7:0] & 8'hbb;
  wire [7:0]   md = {cfg_reg[13:12], cfg_reg[9:8], cfg_reg[5:4], cfg_reg[1:0]};
  wire [3:0]   val = {cfg_reg[15], cfg_reg[11], cfg_reg[7], cfg_reg[3]};
  wire [3:0]   dv = {~md[7] & md[6], ~md[5] & md[4], ~md[3] & md[2], ~md[1] & md[0]};
  wire [3:0]   fn = ~{|md[7:6], |md[5:4], |md[3:2], |md[1:0]};
  wire [7:0]   rd = WB_ADR_I[2] ? cfg_reg[15:8] : cfg_reg[7:0];
  // Shadow of both config registers, updated at the taking edge
  always @(posedge REF_CLK or negedge RST_N)
    if (!RST_N) cfg_reg <= 16'h0000;
    else if (req && WB_WE_I && WB_SEL_I[0] && sel)
      cfg_reg <= WB_ADR_I[2] ? {wd, cfg_reg[7:0]} : {cfg_reg[15:8], wd};
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  ack_latency_a: assert property (req |=> WB_ACK_O)
    else $error("ack missing");
  pin_enable_a: assert property (AUX_IO_PIN_OE_N == ~$past(dv))
    else $error("pin enable wrong");
  pin_level_a: assert property ((AUX_IO_PIN_O & $past(dv)) == $past(val & dv))
    else $error("pin level wrong");
  func_gate_a: assert property ((FUNC_IN & ~$past(fn)) == 4'h0)
    else $error("func input leaks");
  cfg_read_a: assert property (WB_ACK_O && !WB_WE_I && sel |-> WB_DAT_O == {24'h0, rd})
    else $error("config read wrong");
  idle_data_a: assert property (!WB_ACK_O |-> WB_DAT_O == '0)
    else $error("data not zero");
  cover property (req && WB_WE_I);
  cover property (WB_ACK_O && !WB_WE_I && sel);
  cover property (!AUX_IO_PIN_OE_N[3]);
endmodule
bind lgpc_top lgpc_chk lgpc_chk_i (.*);

// file: tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack;
  logic [31:0] adr = '0, dat = '0, dat_o, q;
  logic [3:0]  pin = '0, fin, po, poe;
  logic [7:0]  m [2] = '{8'h00, 8'h00};
  int          n_errors = 0, total_checks = 0, cyc_n = 0, r, d, e, k;
  lgpc_top lgpc_top_i (.REF_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
    .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .FUNC_OUT(4'h0),
    .FUNC_IN(fin), .AUX_IO_PIN_I(pin), .AUX_IO_PIN_O(po),
    .AUX_IO_PIN_OE_N(poe));
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (++cyc_n == 5000) begin
    n_errors++;
    give_verdict();
  end
  task chk(string s, logic [31:0] a, logic [31:0] b);
    total_checks++;
    if (a !== b) begin
      n_errors++;
      $display("ERROR %s exp %h seen %h", s, b, a);
    end
  endtask
  task wb(logic w, logic [7:0] a, logic [7:0] v);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {24'h0, a};
    dat <= {24'h0, v};
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 0;
    stb <= 0;
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    k = $urandom(32'h5a1c);
    repeat (12) @(posedge clk);
    rst_n <= 1;
    wb(0, 8'h40, 0);
    chk("cfg56", q, 0);
    wb(0, 8'h44, 0);
    chk("cfg78", q, 0);
    chk("oe", poe, 4'hf);
    $display("reset test done");
    for (k = 0; k < 32; k++) begin
      r = k & 1;
      d = $urandom;
      d[1:0] = k[2:1];
      d[5:4] = k[4:3];
      wb(1, 8'h40 + 8'(4 * r), d[7:0]);
      m[r] = d[7:0] & 8'hbb;
      wb(0, 8'h40 + 8'(4 * r), 0);
      chk("cfg", q, m[r]);
      pin <= 4'($urandom);
      repeat (5) @(posedge clk);
      for (e = 0; e < 4; e++) begin
        d = m[e / 2] >> (4 * (e % 2));
        chk("oe", poe[e], (d & 3) != 1);
        if ((d & 3) == 1) chk("out", po[e], d[3]);
        chk("fin", fin[e], (d & 3) == 0 && pin[e]);
      end
      wb(0, 8'h48, 0);
      chk("status", q, pin);
    end
    wb(1, 8'h4c, 8'hff);
    wb(0, 8'h4c, 0);
    chk("unmapped", q, 0);
    wb(0, 8'h40, 0);
    chk("cfg56 kept", q, m[0]);
    wb(0, 8'h44, 0);
    chk("cfg78 kept", q, m[1]);
    $display("config test done");
    give_verdict();
  end
endmodule
